// *** rtl/vopc_pkg.sv ***
// Constants of the video output port control block: register map, fields
// and codes. Assumes nothing of its surroundings.
package vopc_pkg;
	localparam logic [7:0] ADDR_OUTPUT_PORT_CONTROL = 8'h13;
	localparam logic [7:0] ADDR_ANALOG_ADC_COMPAT   = 8'h14;
	// All control bits start cleared so both output enables, rt_ctrl_out_en and crystal_out_en, start off
	localparam logic [7:0] RESET_OUTPUT_PORT_CONTROL = 8'h00;
	localparam logic [7:0] RESET_ANALOG_ADC_COMPAT   = 8'h00;
	localparam logic [7:0] READ_UNMAPPED = 8'h00;
	// Output port control fields
	localparam int RT_CTRL_OUT_EN_BIT        = 7;
	localparam int XPORT_HSEL_BIT            = 6;
	localparam int XPORT_VSEL_HI             = 5;
	localparam int XPORT_VSEL_LO             = 4;
	localparam int LOCK_INDICATOR_SELECT_BIT = 3;
	localparam int FORMAT_HI                 = 2;
	localparam int FORMAT_LO                 = 0;
	// Analog, converter and compatibility fields
	localparam int COMPAT_BIT                = 7;
	localparam int AGC_UPDATE_INTERVAL_BIT   = 6;
	localparam int TEST_SELECT_HI            = 5;
	localparam int TEST_SELECT_LO            = 4;
	localparam int CRYSTAL_OUT_EN_BIT        = 3;
	localparam int AUTO_STD_BIT              = 2;
	localparam int SAMPLE_CLOCK_PHASE_HI     = 1;
	localparam int SAMPLE_CLOCK_PHASE_LO     = 0;
	// Horizontal fine delay taps, one clock per half pixel clock step
	localparam int HSYNC_DELAY_TAPS = 4;
	typedef enum logic [1:0] {
		VOPC_VSEL_VSYNC     = 2'b00,
		VOPC_VSEL_FIELD     = 2'b01,
		VOPC_VSEL_VSYNC_INV = 2'b10,
		VOPC_VSEL_FIELD_INV = 2'b11
	} vopc_vsel_t;
	typedef enum logic [2:0] {
		VOPC_FMT_CODES     = 3'b000,
		VOPC_FMT_GATED     = 3'b001,
		VOPC_FMT_NOCODES   = 3'b010,
		VOPC_FMT_RSVD3     = 3'b011,
		VOPC_FMT_BYP_HIGH  = 3'b100,
		VOPC_FMT_BYP_LOW   = 3'b101,
		VOPC_FMT_RSVD6     = 3'b110,
		VOPC_FMT_BYP_SPLIT = 3'b111
	} vopc_fmt_t;
	localparam logic [2:0] TEST_GROUND   = 3'h0;
	localparam logic [2:0] TEST_INPUT4   = 3'h4;
	localparam logic [2:0] TEST_BANDPASS = 3'h7;
endpackage : vopc_pkg

// *** rtl/vopc_delay_line.sv ***
// Tapped delay line for the horizontal sync pulse fine position.
// Assumes one clock equals one half pixel clock step.
`timescale 1ns/1ps
`default_nettype none
module vopc_delay_line #(
	parameter int TAPS = 4
) (
	input  wire logic                    clk,
	input  wire logic                    reset_n,
	input  wire logic                    din,
	input  wire logic [$clog2(TAPS)-1:0] tap_sel,
	output logic                         dout
);
	logic [TAPS-1:0] stage_reg;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			stage_reg <= '0;
		end else begin
			stage_reg <= {stage_reg[TAPS-2:0], din};
		end
	end

	assign dout = stage_reg[tap_sel];
endmodule : vopc_delay_line
`default_nettype wire

// *** rtl/vopc_port_ctrl.sv ***
// Video output port control: two control registers and the port muxes.
// Assumes a serial bus slave presents subaddress writes and reads here,
// and that sync, lock and sample inputs are synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module vopc_port_ctrl (
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_write,
	output logic [7:0]      reg_rdata,
	input  wire logic [1:0] hsync_fine_delay,
	input  wire logic       test_select_msb,
	input  wire logic       active_line_reference,
	input  wire logic       horiz_sync_pulse,
	input  wire logic       vertical_sync_signal,
	input  wire logic       field_id,
	input  wire logic       horiz_lock_status,
	input  wire logic       fast_lock_indicator,
	input  wire logic       clock_reference_toggle,
	input  wire logic       two_converters,
	input  wire logic [7:0] video_with_codes,
	input  wire logic [7:0] video_gated,
	input  wire logic [7:0] video_no_codes,
	input  wire logic [8:0] converter_first,
	input  wire logic [8:0] converter_second,
	input  wire logic       line_start,
	input  wire logic       field_start,
	input  wire logic       realtime_control_in,
	output logic            xport_horiz_out,
	output logic            xport_vert_out,
	output logic            lock_indicator_out,
	output logic [7:0]      video_data_out,
	output logic            agc_update,
	output logic [2:0]      analog_test_select,
	output logic            realtime_control_output,
	output logic            rt_ctrl_out_en,
	output logic            crystal_out_en,
	output logic [1:0]      sample_clock_phase,
	output logic            compat_mode,
	output logic            auto_std_detect
);
	logic [7:0] output_port_control_reg;
	logic [7:0] analog_adc_compat_control_reg;
	logic       hs_delayed;
	logic [2:0] test_sel_raw;
	logic [7:0] video_data_next;

	// Register writes
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			output_port_control_reg <= vopc_pkg::RESET_OUTPUT_PORT_CONTROL;
		end else if (reg_write &&
			reg_addr == vopc_pkg::ADDR_OUTPUT_PORT_CONTROL) begin
			output_port_control_reg <= reg_wdata;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			analog_adc_compat_control_reg <= vopc_pkg::RESET_ANALOG_ADC_COMPAT;
		end else if (reg_write &&
			reg_addr == vopc_pkg::ADDR_ANALOG_ADC_COMPAT) begin
			analog_adc_compat_control_reg <= reg_wdata;
		end
	end

	// Read data follows the address one cycle later
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= vopc_pkg::READ_UNMAPPED;
		end else begin
			case (reg_addr)
				vopc_pkg::ADDR_OUTPUT_PORT_CONTROL: begin
					reg_rdata <= output_port_control_reg;
				end
				vopc_pkg::ADDR_ANALOG_ADC_COMPAT: begin
					reg_rdata <= analog_adc_compat_control_reg;
				end
				default: begin
					reg_rdata <= vopc_pkg::READ_UNMAPPED;
				end
			endcase
		end
	end

	// Pulse width comes from the sync generator; only the fine shift is here
	vopc_delay_line #(
		.TAPS(vopc_pkg::HSYNC_DELAY_TAPS)
	) u_hs_delay (
		.clk    (clk),
		.reset_n(reset_n),
		.din    (horiz_sync_pulse),
		.tap_sel(hsync_fine_delay),
		.dout   (hs_delayed)
	);

	// Sync and lock outputs
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			xport_horiz_out    <= 1'b0;
			xport_vert_out     <= 1'b0;
			lock_indicator_out <= 1'b0;
		end else begin
			xport_horiz_out <= output_port_control_reg[vopc_pkg::XPORT_HSEL_BIT]
				? hs_delayed : active_line_reference;
			case (output_port_control_reg[vopc_pkg::XPORT_VSEL_HI:
				vopc_pkg::XPORT_VSEL_LO])
				vopc_pkg::VOPC_VSEL_VSYNC: begin
					xport_vert_out <= vertical_sync_signal;
				end
				vopc_pkg::VOPC_VSEL_FIELD: begin
					xport_vert_out <= field_id;
				end
				vopc_pkg::VOPC_VSEL_VSYNC_INV: begin
					xport_vert_out <= ~vertical_sync_signal;
				end
				default: begin
					xport_vert_out <= ~field_id;
				end
			endcase
			lock_indicator_out <=
				output_port_control_reg[vopc_pkg::LOCK_INDICATOR_SELECT_BIT]
				? fast_lock_indicator
				: ~horiz_lock_status;
		end
	end

	// Output data format; reserved codes drive zero to keep the port quiet
	always_comb begin
		video_data_next = 8'h00;
		case (output_port_control_reg[vopc_pkg::FORMAT_HI:vopc_pkg::FORMAT_LO])
			vopc_pkg::VOPC_FMT_CODES: begin
				video_data_next = video_with_codes;
			end
			vopc_pkg::VOPC_FMT_GATED: begin
				video_data_next = video_gated;
			end
			vopc_pkg::VOPC_FMT_NOCODES: begin
				video_data_next = video_no_codes;
			end
			vopc_pkg::VOPC_FMT_BYP_HIGH: begin
				video_data_next = (two_converters && clock_reference_toggle)
					? converter_second[8:1] : converter_first[8:1];
			end
			vopc_pkg::VOPC_FMT_BYP_LOW: begin
				video_data_next = (two_converters && clock_reference_toggle)
					? converter_second[7:0] : converter_first[7:0];
			end
			vopc_pkg::VOPC_FMT_BYP_SPLIT: begin
				// Only the first converter is used; a second one is ignored
				video_data_next = clock_reference_toggle
					? converter_first[8:1] : converter_first[7:0];
			end
			default: begin
				video_data_next = 8'h00;
			end
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			video_data_out <= 8'h00;
		end else begin
			video_data_out <= video_data_next;
		end
	end

	// Gain update strobe
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			agc_update <= 1'b0;
		end else begin
			agc_update <=
				analog_adc_compat_control_reg[vopc_pkg::AGC_UPDATE_INTERVAL_BIT]
				? field_start
				: line_start;
		end
	end

	// Analog test routing; reserved selections fall back to ground
	assign test_sel_raw = {test_select_msb,
		analog_adc_compat_control_reg[vopc_pkg::TEST_SELECT_HI:
		vopc_pkg::TEST_SELECT_LO]};

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			analog_test_select <= vopc_pkg::TEST_GROUND;
		end else if (test_sel_raw <= vopc_pkg::TEST_INPUT4 ||
			test_sel_raw == vopc_pkg::TEST_BANDPASS) begin
			analog_test_select <= test_sel_raw;
		end else begin
			analog_test_select <= vopc_pkg::TEST_GROUND;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			realtime_control_output <= 1'b0;
		end else begin
			realtime_control_output <= realtime_control_in;
		end
	end

	assign rt_ctrl_out_en =
		output_port_control_reg[vopc_pkg::RT_CTRL_OUT_EN_BIT];
	assign crystal_out_en =
		analog_adc_compat_control_reg[vopc_pkg::CRYSTAL_OUT_EN_BIT];
	assign sample_clock_phase = analog_adc_compat_control_reg[
		vopc_pkg::SAMPLE_CLOCK_PHASE_HI:vopc_pkg::SAMPLE_CLOCK_PHASE_LO];
	assign compat_mode = analog_adc_compat_control_reg[vopc_pkg::COMPAT_BIT];
	assign auto_std_detect =
		analog_adc_compat_control_reg[vopc_pkg::AUTO_STD_BIT];

	// Checks
	a_active_line_reference_path: assert property (@(posedge clk) disable iff (!reset_n)
		!output_port_control_reg[6]
		|=> xport_horiz_out == $past(active_line_reference))
		else $error("horizontal out does not follow line reference");
	a_hs_delay_zero: assert property (@(posedge clk) disable iff (!reset_n)
		output_port_control_reg[6] && hsync_fine_delay == 2'h0
		|=> xport_horiz_out == $past(horiz_sync_pulse, 2))
		else $error("sync pulse delay wrong at step zero");
	a_hs_delay_three: assert property (@(posedge clk) disable iff (!reset_n)
		output_port_control_reg[6] && hsync_fine_delay == 2'h3
		|=> xport_horiz_out == $past(horiz_sync_pulse, 5))
		else $error("sync pulse delay wrong at step three");
	a_vert_field: assert property (@(posedge clk) disable iff (!reset_n)
		output_port_control_reg[5:4] == 2'b01
		|=> xport_vert_out == $past(field_id))
		else $error("vertical out does not carry field id");
	a_vert_inverted: assert property (@(posedge clk) disable iff (!reset_n)
		output_port_control_reg[5:4] == 2'b10
		|=> xport_vert_out != $past(vertical_sync_signal))
		else $error("vertical out not inverted sync");
	a_lock_standard: assert property (@(posedge clk) disable iff (!reset_n)
		!output_port_control_reg[3]
		|=> lock_indicator_out == !$past(horiz_lock_status))
		else $error("lock indicator not inverted status");
	a_lock_fast: assert property (@(posedge clk) disable iff (!reset_n)
		output_port_control_reg[3]
		|=> lock_indicator_out == $past(fast_lock_indicator))
		else $error("lock indicator not fast source");
	a_fmt_gated: assert property (@(posedge clk) disable iff (!reset_n)
		output_port_control_reg[2:0] == 3'b001
		|=> video_data_out == $past(video_gated))
		else $error("gated format data wrong");
	a_fmt_nocodes: assert property (@(posedge clk) disable iff (!reset_n)
		output_port_control_reg[2:0] == 3'b010
		|=> video_data_out == $past(video_no_codes))
		else $error("code free format data wrong");
	a_byp_high_pair: assert property (@(posedge clk) disable iff (!reset_n)
		output_port_control_reg[2:0] == 3'b100 && two_converters
		&& clock_reference_toggle
		|=> video_data_out == $past(converter_second[8:1]))
		else $error("high bypass second converter wrong");
	a_byp_low_first: assert property (@(posedge clk) disable iff (!reset_n)
		output_port_control_reg[2:0] == 3'b101 && !clock_reference_toggle
		|=> video_data_out == $past(converter_first[7:0]))
		else $error("low bypass first converter wrong");
	a_split_low: assert property (@(posedge clk) disable iff (!reset_n)
		output_port_control_reg[2:0] == 3'b111 && !clock_reference_toggle
		|=> video_data_out == $past(converter_first[7:0]))
		else $error("split bypass low half wrong");
	a_agc_field: assert property (@(posedge clk) disable iff (!reset_n)
		analog_adc_compat_control_reg[6] && !field_start |=> !agc_update)
		else $error("gain update outside field start");
	a_agc_line: assert property (@(posedge clk) disable iff (!reset_n)
		!analog_adc_compat_control_reg[6] && line_start |=> agc_update)
		else $error("gain update missed line start");
	a_test_reserved: assert property (@(posedge clk) disable iff (!reset_n)
		test_sel_raw == 3'h5 |=> analog_test_select == 3'h0)
		else $error("reserved test select not grounded");
	a_rt_enable: assert property (@(posedge clk) disable iff (!reset_n)
		reg_write && reg_addr == 8'h13 |=> rt_ctrl_out_en == $past(reg_wdata[7]))
		else $error("control output enable not written");
	a_xtal_enable: assert property (@(posedge clk) disable iff (!reset_n)
		reg_write && reg_addr == 8'h14 |=> crystal_out_en == $past(reg_wdata[3]))
		else $error("crystal output enable not written");
endmodule : vopc_port_ctrl
`default_nettype wire

// *** tb/vopc_video_sink.sv ***
// Downstream video sink model: takes the port data on every rising clock edge.
// Assumes it shares clk and reset_n with the port control block.
`timescale 1ns/1ps
`default_nettype none
module vopc_video_sink (
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire logic [7:0] video_data_out,
	output logic [7:0]      sink_data
);
	// A plain receiver never stalls the port, so no handshake is modelled
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			sink_data <= 8'h00;
		else
			sink_data <= video_data_out;
	end
endmodule : vopc_video_sink
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench for the video output port control block.
// Assumes the package and the block are compiled before this file.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic       clk = 1'h0, reset_n = 1'h0, reg_write = 1'h0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
	logic [1:0] hsync_fine_delay = 2'h0;
	logic       test_select_msb = 1'h0, active_line_reference = 1'h1;
	logic       horiz_sync_pulse = 1'h0, vertical_sync_signal = 1'h1;
	logic       field_id = 1'h0, horiz_lock_status = 1'h1;
	logic       fast_lock_indicator = 1'h1, clock_reference_toggle = 1'h0;
	logic       two_converters = 1'h0, line_start = 1'h0;
	logic       field_start = 1'h0, realtime_control_in = 1'h0;
	logic [7:0] video_with_codes = 8'h11, video_gated = 8'h22;
	logic [7:0] video_no_codes = 8'h33;
	logic [8:0] converter_first = 9'h1A5, converter_second = 9'h0F3;
	logic [7:0] reg_rdata, video_data_out, sink_data;
	logic       xport_horiz_out, xport_vert_out, lock_indicator_out;
	logic       agc_update, realtime_control_output, rt_ctrl_out_en;
	logic       crystal_out_en, compat_mode, auto_std_detect;
	logic [2:0] analog_test_select;
	logic [1:0] sample_clock_phase;
	int         err_total = 0, checks_done = 0, cyc = 0;

	vopc_port_ctrl dut (.clk, .reset_n, .reg_addr, .reg_wdata, .reg_write,
		.reg_rdata, .hsync_fine_delay, .test_select_msb,
		.active_line_reference, .horiz_sync_pulse, .vertical_sync_signal,
		.field_id, .horiz_lock_status, .fast_lock_indicator,
		.clock_reference_toggle, .two_converters, .video_with_codes,
		.video_gated, .video_no_codes, .converter_first, .converter_second,
		.line_start, .field_start, .realtime_control_in, .xport_horiz_out,
		.xport_vert_out, .lock_indicator_out, .video_data_out, .agc_update,
		.analog_test_select, .realtime_control_output, .rt_ctrl_out_en,
		.crystal_out_en, .sample_clock_phase, .compat_mode,
		.auto_std_detect);
	vopc_video_sink sink (.clk, .reset_n, .video_data_out, .sink_data);

	always #4 clk = ~clk;

	// A few hundred cycles are needed; the ceiling leaves a wide margin
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			err_total++;
			complete_run();
		end
	end

	task automatic complete_run;
		$display("Checks %0d, mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : complete_run

	task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// Three edges cover the one-cycle output and read latencies
	task automatic settle;
		repeat (3) @(posedge clk);
		#1;
	endtask : settle

	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_write <= 1'h1;
		@(posedge clk);
		reg_write <= 1'h0;
	endtask : reg_wr

	task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		settle();
		d = reg_rdata;
	endtask : reg_rd

	function automatic logic [7:0] fmt_exp(input logic [2:0] f,
		input logic c, input logic t);
		case (f)
			3'h0: return video_with_codes;
			3'h1: return video_gated;
			3'h2: return video_no_codes;
			3'h4: return (t && c)
				? converter_second[8:1] : converter_first[8:1];
			3'h5: return (t && c)
				? converter_second[7:0] : converter_first[7:0];
			3'h7: return c ? converter_first[8:1] : converter_first[7:0];
			default: return 8'h00;
		endcase
	endfunction : fmt_exp

	initial begin
		logic [7:0] d;
		logic       seen;
		int         n;
		repeat (3) @(posedge clk);
		reset_n <= 1'h1;
		reg_rd(8'h13, d);
		chk(d, vopc_pkg::RESET_OUTPUT_PORT_CONTROL);
		chk(lock_indicator_out, 1'h0);
		reg_wr(8'h13, 8'hA5);
		reg_wr(8'h14, 8'h5A);
		reg_wr(8'h15, 8'hFF);
		reg_rd(8'h13, d);
		chk(d, 8'hA5);
		reg_rd(8'h14, d);
		chk(d, 8'h5A);
		reg_rd(8'h15, d);
		chk(d, vopc_pkg::READ_UNMAPPED);
		chk(rt_ctrl_out_en, 1'h1);
		chk(crystal_out_en, 1'h1);
		chk({compat_mode, auto_std_detect, sample_clock_phase}, 4'h2);
		@(posedge clk);
		realtime_control_in <= 1'h1;
		settle();
		chk(realtime_control_output, 1'h1);
		for (int i = 0; i < 4; i++) begin
			reg_wr(8'h13, 8'(i << 4));
			settle();
			chk(xport_vert_out, (i[0] ? 1'h0 : 1'h1) ^ i[1]);
		end
		chk(rt_ctrl_out_en, 1'h0);
		for (int i = 0; i < 2; i++) begin
			reg_wr(8'h13, 8'(i << 3));
			settle();
			chk(lock_indicator_out, i[0]);
		end
		// Bypass split mode is fed one converter only; every other code, 011/110 included, two
		for (int f = 0; f < 8; f++)
			for (int c = 0; c < 2; c++) begin
				@(posedge clk);
				clock_reference_toggle <= c[0];
				two_converters <= (f != 7);
				reg_wr(8'h13, 8'(f));
				settle();
				d = fmt_exp(3'(f), c[0], f != 7);
				chk(sink_data, d);
			end
		reg_wr(8'h13, 8'h00);
		settle();
		chk(xport_horiz_out, 1'h1);
		reg_wr(8'h13, 8'h40);
		for (int k = 0; k < 4; k++) begin
			@(posedge clk);
			hsync_fine_delay <= 2'(k);
			settle();
			@(posedge clk);
			horiz_sync_pulse <= 1'h1;
			n = 0;
			do begin
				@(posedge clk);
				horiz_sync_pulse <= 1'h0;
				#1;
				n++;
			end while (xport_horiz_out !== 1'h1 && n < 20);
			chk(9'(n), 9'(2 + k));
		end
		for (int u = 0; u < 2; u++) begin
			reg_wr(8'h14, 8'(u << 6));
			for (int k = 0; k < 2; k++) begin
				@(posedge clk);
				line_start  <= ~k[0];
				field_start <= k[0];
				seen = 1'h0;
				repeat (3) begin
					@(posedge clk);
					line_start  <= 1'h0;
					field_start <= 1'h0;
					#1;
					seen = seen | agc_update;
				end
				chk(seen, k == u);
			end
		end
		for (int t = 0; t < 8; t++) begin
			@(posedge clk);
			test_select_msb <= t[2];
			reg_wr(8'h14, {2'h0, t[1:0], 4'h0});
			settle();
			d = (t == 5 || t == 6) ? 8'h00 : 8'(t);
			chk(analog_test_select, d);
		end
		chk(crystal_out_en, 1'h0);
		complete_run();
	end
endmodule : tb_top
`default_nettype wire
